// ==== dcd_pkg.sv ====
// constants shared by the dual oscillator clock block and its divider
// assumes one 100 MHz system clock that oversamples both oscillators
package dcd_pkg;
    localparam int DCD_SYS_CLK_HZ = 100_000_000;
    localparam int DCD_HI_OSC_MAX_HZ = 10_000_000;
    localparam int DCD_LO_OSC_HZ = 32_768;
    // core clock is twice the oscillator rate
    localparam int DCD_MCLK_MULT = 2;
    // core clock periods per instruction cycle
    localparam int DCD_INSTR_DIV = 10;
    // target oscillator rising edges seen before execution moves onto it
    localparam int DCD_SETTLE_EDGES = 16;
    localparam int DCD_SETTLE_W = 5;
    // pin indices of the shared low speed oscillator port pins
    localparam int DCD_PIN_LO_IN = 0;
    localparam int DCD_PIN_LO_OUT = 1;
    localparam logic DCD_HI_ON_RST = 1'b1;
    localparam logic DCD_SEL_LOW_RST = 1'b0;

    // gray codes along hi -> to_lo -> lo -> to_hi -> hi
    typedef enum logic [1:0] {
        DCD_HI_RUN = 2'b00,
        DCD_TO_LO = 2'b01,
        DCD_LO_RUN = 2'b11,
        DCD_TO_HI = 2'b10
    } dcd_state_e;
endpackage

// ==== dcd_instr_div.sv ====
// divides core clock ticks into instruction cycle ticks
// assumes mclk_tick is a one cycle pulse per core clock period
`timescale 1ns/1ps
`default_nettype none
module dcd_instr_div
    import dcd_pkg::*;
#(
    parameter int DIV = DCD_INSTR_DIV
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // core clock tick in
    input wire logic mclk_tick,
    // instruction cycle out
    output logic instr_tick,
    output logic instr_phase
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2);

    if (DIV < 2) begin : g_div_check
        $error("instruction divider must be at least 2");
    end

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic tick_reg;
    logic phase_reg;
    wire at_last = (count_reg == LAST);

    assign count_next = at_last ? '0 : count_reg + 1'b1;

    // one tick per DIV core clock periods
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
            phase_reg <= 1'b0;
        end else begin
            tick_reg <= mclk_tick & at_last;
            if (mclk_tick) begin
                count_reg <= count_next;
                phase_reg <= (count_next < HALF);
            end
        end
    end

    assign instr_tick = tick_reg;
    assign instr_phase = phase_reg;
endmodule
`default_nettype wire

// ==== dcd_clock_ctrl.sv ====
// dual oscillator clock control with clock doubler
// assumes oscillator pin levels are already synchronous to clock
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - high speed oscillator up to 10 MHz
// - low speed oscillator for 32.768 kHz crystal
// - core clock is twice selected oscillator rate
// - instruction cycle is ten core clock periods
// - software moves execution between oscillators by sequence
// - oscillator not in use may be stopped
// - unused low oscillator pins become bidirectional gpio
// - L0/L1 shared with wakeup; L1 clock out
module dcd_clock_ctrl
    import dcd_pkg::*;
#(
    parameter int SYS_CLK_HZ = DCD_SYS_CLK_HZ,
    parameter int HI_OSC_MAX_HZ = DCD_HI_OSC_MAX_HZ,
    parameter int SETTLE_EDGES = DCD_SETTLE_EDGES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // high speed oscillator amplifier
    input wire logic hi_osc_in,
    output logic hi_osc_out,
    // shared port pins L0 and L1
    input wire logic [1:0] l_in,
    output logic [1:0] l_out,
    output logic [1:0] l_oe,
    // port logic side of L0 and L1
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe,
    output logic [1:0] gpio_in,
    output logic [1:0] multi_input_wakeup,
    // software control levels
    input wire logic lo_osc_enable,
    input wire logic low_speed_req,
    input wire logic hi_osc_off_req,
    input wire logic lo_osc_off_req,
    input wire logic ckx_out_en,
    // status and clocks out
    output logic low_speed_active,
    output logic hi_osc_running,
    output logic lo_osc_running,
    output logic selected_osc_frequency,
    output logic mclk_tick,
    output logic instr_tick
);
    ////////////////////////////////////////////////////////////////////////
    // the sampled edge pulses need four samples per oscillator period
    if (SYS_CLK_HZ < 4 * HI_OSC_MAX_HZ) begin : g_clk_check
        $error("system clock too slow for high speed oscillator");
    end
    // a single edge is no evidence that a crystal has started
    if (SETTLE_EDGES < 2 || SETTLE_EDGES > 31) begin : g_settle_check
        $error("settle edge count out of range");
    end

    localparam logic [DCD_SETTLE_W-1:0] SETTLE_LAST =
        DCD_SETTLE_W'(SETTLE_EDGES - 1);

    dcd_state_e state_reg;
    dcd_state_e state_next;
    logic [DCD_SETTLE_W-1:0] settle_reg;
    logic hi_prev_reg;
    logic lo_prev_reg;
    logic hi_on_reg;
    logic lo_on_reg;
    logic sel_low_reg;
    logic mclk_reg;
    logic sel_rise_reg;
    logic hi_out_reg;
    logic [1:0] gpio_in_reg;
    logic [1:0] wake_reg;
    logic instr_phase;

    ////////////////////////////////////////////////////////////////////////
    // edge detection on both oscillators
    wire lo_level = l_in[DCD_PIN_LO_IN];
    wire hi_edge = (hi_osc_in ^ hi_prev_reg) & hi_on_reg;
    wire lo_edge = (lo_level ^ lo_prev_reg) & lo_on_reg;
    wire hi_rise = hi_edge & hi_osc_in;
    wire lo_rise = lo_edge & lo_level;
    // both edges of the selected oscillator make a core tick
    wire sel_edge = sel_low_reg ? lo_edge : hi_edge;
    wire sel_rise = sel_low_reg ? lo_rise : hi_rise;

    ////////////////////////////////////////////////////////////////////////
    // transition sequence
    wire in_hi = (state_reg == DCD_HI_RUN);
    wire in_lo = (state_reg == DCD_LO_RUN);
    wire target_rise = (state_reg == DCD_TO_LO) ? lo_rise : hi_rise;
    wire settled = target_rise && (settle_reg == SETTLE_LAST);
    wire to_lo_ok = low_speed_req & lo_osc_enable;

    // switch only once the target oscillator has shown stable edges
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DCD_HI_RUN: begin
                if (to_lo_ok) state_next = DCD_TO_LO;
            end
            DCD_TO_LO: begin
                if (!to_lo_ok) state_next = DCD_HI_RUN;
                else if (settled) state_next = DCD_LO_RUN;
            end
            DCD_LO_RUN: begin
                if (!to_lo_ok) state_next = DCD_TO_HI;
            end
            DCD_TO_HI: begin
                if (settled) state_next = DCD_HI_RUN;
            end
            default: state_next = DCD_HI_RUN;
        endcase
    end

    // a stop request stops only the idle oscillator, but clearing lo_osc_enable stops the low one in any state; a sequence restarts it
    wire hi_on_next = in_lo ? ~hi_osc_off_req : 1'b1;
    wire lo_on_next = lo_osc_enable & (in_hi ? ~lo_osc_off_req : 1'b1);
    wire sel_low_next = (state_next == DCD_LO_RUN) |
        (state_next == DCD_TO_HI);
    wire in_seq = (state_reg == DCD_TO_LO) | (state_reg == DCD_TO_HI);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_reg <= DCD_HI_RUN;
            settle_reg <= '0;
            hi_on_reg <= DCD_HI_ON_RST;
            lo_on_reg <= 1'b0;
            sel_low_reg <= DCD_SEL_LOW_RST;
        end else begin
            state_reg <= state_next;
            hi_on_reg <= hi_on_next;
            lo_on_reg <= lo_on_next;
            sel_low_reg <= sel_low_next;
            if (!in_seq || state_next != state_reg) settle_reg <= '0;
            else if (target_rise) settle_reg <= settle_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // doubler, amplifier and pin sampling
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hi_prev_reg <= 1'b0;
            lo_prev_reg <= 1'b0;
            mclk_reg <= 1'b0;
            sel_rise_reg <= 1'b0;
            hi_out_reg <= 1'b0;
            gpio_in_reg <= 2'h0;
            wake_reg <= 2'h0;
        end else begin
            hi_prev_reg <= hi_osc_in;
            lo_prev_reg <= lo_level;
            mclk_reg <= sel_edge;
            sel_rise_reg <= sel_rise;
            hi_out_reg <= hi_on_reg & ~hi_osc_in;
            gpio_in_reg <= l_in;
            wake_reg <= l_in; // wakeup always sees both pins
        end
    end

    dcd_instr_div #(
        .DIV(DCD_INSTR_DIV)
    ) u_div (
        .clock(clock),
        .reset_n(reset_n),
        .mclk_tick(mclk_reg),
        .instr_tick(instr_tick),
        .instr_phase(instr_phase)
    );

    ////////////////////////////////////////////////////////////////////////
    // L0/L1 sharing: oscillator, clock out or plain port
    wire lo_drive = ~lo_level & lo_on_reg;
    wire l1_osc_out = lo_osc_enable ? lo_drive :
        (ckx_out_en ? instr_phase : gpio_out[DCD_PIN_LO_OUT]);
    wire l1_osc_oe = lo_osc_enable | ckx_out_en | gpio_oe[DCD_PIN_LO_OUT];

    assign l_out = {l1_osc_out, lo_osc_enable ? 1'b0 : gpio_out[0]};
    assign l_oe = {l1_osc_oe, lo_osc_enable ? 1'b0 : gpio_oe[0]};
    assign gpio_in = gpio_in_reg;
    assign multi_input_wakeup = wake_reg;
    assign hi_osc_out = hi_out_reg;
    assign low_speed_active = sel_low_reg;
    assign hi_osc_running = hi_on_reg;
    assign lo_osc_running = lo_on_reg;
    assign selected_osc_frequency = sel_rise_reg;
    assign mclk_tick = mclk_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence lo_req_held;
        to_lo_ok [*2];
    endsequence

    doubler_tick_a: assert property (@(posedge clock) disable iff (!reset_n)
        sel_edge |=> mclk_tick)
        else $error("selected edge did not give a core tick");

    doubler_rate_a: assert property (@(posedge clock) disable iff (!reset_n)
        selected_osc_frequency |-> mclk_tick)
        else $error("oscillator rise without core tick");

    instr_ratio_a: assert property (@(posedge clock) disable iff (!reset_n)
        instr_tick |-> $past(mclk_tick))
        else $error("instruction tick not aligned to core tick");

    hi_stop_only_a: assert property (@(posedge clock) disable iff (!reset_n)
        !hi_osc_running |-> low_speed_active)
        else $error("high oscillator stopped while selected");

    lo_stop_only_a: assert property (@(posedge clock) disable iff (!reset_n)
        (low_speed_active && lo_osc_enable) |-> lo_osc_running)
        else $error("low oscillator stopped while selected");

    seq_start_a: assert property (@(posedge clock) disable iff (!reset_n)
        (in_hi ##1 lo_req_held) |-> state_reg == DCD_TO_LO)
        else $error("low speed request not started");

    // separate count of low rises while waiting, so the check is not
    // just the settle counter compared with itself
    localparam logic [DCD_SETTLE_W-1:0] SETTLE_FULL =
        DCD_SETTLE_W'(SETTLE_EDGES);
    logic [DCD_SETTLE_W-1:0] lo_seen_reg;

    always_ff @(posedge clock) begin
        if (!reset_n || state_reg != DCD_TO_LO) begin
            lo_seen_reg <= '0;
        end else if (lo_rise) begin
            lo_seen_reg <= lo_seen_reg + 1'b1;
        end
    end

    settle_wait_a: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(low_speed_active) |-> lo_seen_reg == SETTLE_FULL)
        else $error("switched before settle count");

    gpio_free_a: assert property (@(posedge clock) disable iff (!reset_n)
        !lo_osc_enable |-> l_oe[0] == gpio_oe[0])
        else $error("L0 not returned to port use");

    l1_osc_drive_a: assert property (@(posedge clock) disable iff (!reset_n)
        lo_osc_enable |-> l_oe == 2'h2)
        else $error("L1 not driving oscillator output");

    wake_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
        ##1 multi_input_wakeup == $past(l_in))
        else $error("wakeup does not follow pins");
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the dual oscillator clock block
// assumes dcd_pkg and the design modules are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb
    import dcd_pkg::*;
;
logic clock = 1'b0;
logic reset_n = 1'b0;
logic hi_osc_in = 1'b0;
logic lo_lvl = 1'b0;
logic l1_lvl = 1'b0;
logic [1:0] gpio_out = 2'h0;
logic [1:0] gpio_oe = 2'h0;
logic lo_osc_enable = 1'b0;
logic low_speed_req = 1'b0;
logic hi_osc_off_req = 1'b0;
logic lo_osc_off_req = 1'b0;
logic ckx_out_en = 1'b0;
logic hi_gen = 1'b0;
logic lo_gen = 1'b0;
wire logic [1:0] l_in;
logic hi_osc_out, low_speed_active, hi_osc_running, lo_osc_running;
logic selected_osc_frequency, mclk_tick, instr_tick;
logic [1:0] l_out, l_oe, gpio_in, multi_input_wakeup;
int n_fail = 0;
int n_checks = 0;
int n_mclk = 0, n_sel = 0, n_instr = 0;
int n_hi_e = 0, n_hi_r = 0, n_lo_e = 0;
int hi_cnt = 0, lo_cnt = 0;

assign l_in = {l1_lvl, lo_lvl};
always #5 clock = ~clock;

dcd_clock_ctrl #(.SETTLE_EDGES(2)) dut (
    .clock(clock), .reset_n(reset_n),
    .hi_osc_in(hi_osc_in), .hi_osc_out(hi_osc_out),
    .l_in(l_in), .l_out(l_out), .l_oe(l_oe),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .multi_input_wakeup(multi_input_wakeup),
    .lo_osc_enable(lo_osc_enable), .low_speed_req(low_speed_req),
    .hi_osc_off_req(hi_osc_off_req), .lo_osc_off_req(lo_osc_off_req),
    .ckx_out_en(ckx_out_en), .low_speed_active(low_speed_active),
    .hi_osc_running(hi_osc_running), .lo_osc_running(lo_osc_running),
    .selected_osc_frequency(selected_osc_frequency),
    .mclk_tick(mclk_tick), .instr_tick(instr_tick)
);

////////////////////////////////////////////////////////////////////////////
// oscillator models: each edge held three or four cycles, over the minimum
always @(posedge clock) begin
    if (hi_gen) begin
        hi_cnt = (hi_cnt == 2) ? 0 : hi_cnt + 1;
        if (hi_cnt == 0) begin
            hi_osc_in <= ~hi_osc_in;
            n_hi_e++;
            if (hi_osc_in == 1'b0) n_hi_r++;
        end
    end
    if (lo_gen) begin
        lo_cnt = (lo_cnt == 3) ? 0 : lo_cnt + 1;
        if (lo_cnt == 0) begin
            lo_lvl <= ~lo_lvl;
            n_lo_e++;
        end
    end
end

always @(posedge clock) begin
    if (mclk_tick === 1'b1) n_mclk++;
    if (selected_osc_frequency === 1'b1) n_sel++;
    if (instr_tick === 1'b1) n_instr++;
end

////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
        n_fail++;
        $display("[FAIL] %0t %s", $time, msg);
    end
endtask

task automatic wait_lsa(input logic v);
    for (int i = 0; i < 300 && low_speed_active !== v; i++) begin
        @(posedge clock);
        #1;
    end
    chk(low_speed_active === v, "low speed status timeout");
endtask

task automatic t_reset_state();
    #1;
    chk(hi_osc_running === 1'b1, "hi osc not running");
    chk(hi_osc_out === 1'b1, "hi amplifier not inverting");
    chk(lo_osc_running === 1'b0, "lo osc running");
    chk(low_speed_active === 1'b0, "low speed at reset");
    chk(mclk_tick === 1'b0 && instr_tick === 1'b0, "reset ticks");
endtask

task automatic t_doubler();
    int m0, s0, e0, r0;
    m0 = n_mclk;
    s0 = n_sel;
    e0 = n_hi_e;
    r0 = n_hi_r;
    @(posedge clock);
    hi_gen <= 1'b1;
    repeat (63) @(posedge clock);
    hi_gen <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk(n_mclk - m0 == n_hi_e - e0, "core ticks per edge");
    chk(n_sel - s0 == n_hi_r - r0, "osc rises");
    chk(n_instr == n_hi_e / DCD_INSTR_DIV, "instr tick count");
endtask

task automatic t_gpio();
    int ph;
    @(posedge clock);
    gpio_oe <= 2'h3;
    gpio_out <= 2'h2;
    l1_lvl <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk(l_oe === 2'h3 && l_out === 2'h2, "gpio drive");
    chk(gpio_in[1] === 1'b1, "gpio input");
    chk(multi_input_wakeup[1] === 1'b1, "wakeup input");
    @(posedge clock);
    gpio_oe <= 2'h0;
    ckx_out_en <= 1'b1;
    @(posedge clock);
    #1;
    // core ticks so far equal the oscillator edges sent by the model
    ph = n_hi_e % DCD_INSTR_DIV;
    chk(l_oe === 2'h2, "clock out enable on L1");
    chk(l_out[1] === (ph < DCD_INSTR_DIV / 2), "clock out phase");
    @(posedge clock);
    ckx_out_en <= 1'b0;
endtask

task automatic t_low_speed();
    int m0, e0;
    @(posedge clock);
    lo_osc_enable <= 1'b1;
    low_speed_req <= 1'b1;
    lo_gen <= 1'b1;
    wait_lsa(1'b1);
    chk(lo_osc_running === 1'b1, "lo osc off");
    chk(l_oe === 2'h2 && l_out[1] === ~lo_lvl, "osc pins drive");
    @(posedge clock);
    hi_osc_off_req <= 1'b1;
    lo_gen <= 1'b0;
    hi_gen <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk(hi_osc_running === 1'b0, "hi osc not stopped");
    chk(hi_osc_out === 1'b0, "hi amplifier not stopped");
    m0 = n_mclk;
    e0 = n_lo_e;
    // hi osc keeps toggling here: a stopped osc must give no ticks
    @(posedge clock);
    lo_gen <= 1'b1;
    repeat (80) @(posedge clock);
    lo_gen <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk(n_mclk - m0 == n_lo_e - e0, "low speed doubling");
endtask

task automatic t_return_high();
    @(posedge clock);
    hi_osc_off_req <= 1'b0;
    low_speed_req <= 1'b0;
    wait_lsa(1'b0);
    chk(hi_osc_running === 1'b1, "hi osc not restarted");
    @(posedge clock);
    lo_osc_off_req <= 1'b1;
    hi_gen <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk(lo_osc_running === 1'b0, "lo osc not stopped");
endtask

// request low speed with a silent crystal, then give up waiting
task automatic t_abort();
    @(posedge clock);
    low_speed_req <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk(lo_osc_running === 1'b1, "lo osc not restarted");
    chk(low_speed_active === 1'b0, "switched with no lo edges");
    @(posedge clock);
    low_speed_req <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk(lo_osc_running === 1'b0, "abort did not return high");
    chk(low_speed_active === 1'b0, "low speed after abort");
endtask

task automatic close_out();
    if (n_fail == 0 && n_checks > 0) begin
        $display("TEST PASSED");
    end else begin
        $display("TEST FAILED");
    end
    $finish;
endtask

// whole run is well under a thousand cycles
initial begin
    #50000;
    n_fail++;
    close_out();
end

initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_reset_state();
    t_doubler();
    t_gpio();
    t_low_speed();
    t_return_high();
    t_abort();
    close_out();
end
endmodule
`default_nettype wire
